// ---- src/gct_pkg.sv ----
// Constants for the gated compare timer
package gct_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GCT_CTRL_OFS = 8'h00;
  localparam logic [7:0] GCT_COUNT_OFS = 8'h04;
  localparam logic [7:0] GCT_RELOAD_OFS = 8'h08;
  localparam logic [7:0] GCT_STATUS_OFS = 8'h0c;
  localparam logic [7:0] GCT_MASK_OFS = 8'h10;
  localparam logic [7:0] GCT_PINS_OFS = 8'h14;
  localparam logic [7:0] GCT_CAPTURE_OFS = 8'h18;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int GCT_CTRL_EN_BIT = 0;
  localparam int GCT_CTRL_POL_BIT = 1;
  localparam int GCT_CTRL_PRESCALE_SELECT_LSB = 2;
  localparam int GCT_CTRL_MODE_LSB = 5;
  localparam int GCT_CTRL_MODEHI_BIT = 8;
  localparam int GCT_CTRL_ALT_BIT = 9;
  localparam int GCT_CTRL_WIDTH = 10;
  localparam logic [9:0] GCT_CTRL_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Status and mask bit positions
  // ----------------------------------------------------------------
  localparam int GCT_EV_RELOAD = 0;
  localparam int GCT_EV_DEASSERT = 1;
  localparam int GCT_EV_CAPTURE = 2;
  localparam int GCT_EV_COUNT = 3;

  // ----------------------------------------------------------------
  // Modes, counter values
  // ----------------------------------------------------------------
  localparam logic [3:0] GCT_MODE_COMPARE = 4'h5;
  localparam logic [3:0] GCT_MODE_GATED = 4'h6;
  // Code for capture restart, not fixed by the mode table
  localparam logic [3:0] GCT_MODE_CAPRST = 4'h8;
  localparam logic [15:0] GCT_COUNT_RESTART = 16'h0001;
  localparam logic [15:0] GCT_COUNT_RESET = 16'h0000;
  localparam logic [15:0] GCT_RELOAD_RESET = 16'h0000;
  localparam int GCT_PRESCALE_SELECT_WIDTH = 3;
  localparam int GCT_DIV_WIDTH = 7;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] GCT_HTRANS_NONSEQ = 2'h2;
  localparam logic GCT_HRESP_OKAY = 1'b0;

endpackage : gct_pkg

// ---- src/gct_sync.sv ----
// Two-flop synchroniser for the timer input pin
`timescale 1ns/1ps
`default_nettype none

module gct_sync
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Asynchronous input and its synchronised level
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : gct_sync

`default_nettype wire

// ---- src/gct_prescaler.sv ----
// Power-of-two prescaler giving a one-cycle count enable
`timescale 1ns/1ps
`default_nettype none

module gct_prescaler
  import gct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic clear,
  input wire logic advance,
  input wire logic [GCT_PRESCALE_SELECT_WIDTH-1:0] prescale_select,
  // Count enable pulse
  output logic tick
);

  logic [GCT_DIV_WIDTH-1:0] div_reg;
  logic [GCT_DIV_WIDTH-1:0] div_mask;

  // Low prescale_select bits of the divider set
  assign div_mask = GCT_DIV_WIDTH'((8'h01 << prescale_select) - 8'h01);
  assign tick = advance && ((div_reg & div_mask) == div_mask);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= '0;
    else if (clear)
      div_reg <= '0;
    else if (advance)
      div_reg <= div_reg + GCT_DIV_WIDTH'(1);
  end

endmodule : gct_prescaler

`default_nettype wire

// ---- src/gct_timer.sv ----
// Gated compare timer with AHB-Lite register slave
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Compare mode counts prescaled system clock, never the timer input.
// [R2] Software loads start count while timer disabled.
// [R3] Software loads compare value into reload; interval is difference times prescale.
// [R4] Software disables, configures, loads counts, then enables the timer.
// [R5] Gated mode advances only while input at polarity-selected active level.
// [R6] Gated mode interrupts on input deassertion and on reload.
// [R7] Gated mode counts to reload, interrupts, restarts at 0001, continues.
// [R8] Gated count clock is system clock gated by input, not input edges.
// [R9] Output toggles on each reload when alternate function enabled.
// [R10] Software compares input level to polarity to tell interrupt causes.
// [R11] Capture restart: polarity 0 captures rising edge, 1 falling edge.
// [R12] Prescaler divides by two to the 3-bit setting, cleared when disabled.
// [R13] Mode is high bit plus 3-bit field; 0101 compare, 0110 gated.
// [R14] While disabled the output follows the polarity bit.
// [R15] Compare match interrupts, toggles output if enabled, keeps counting.
module gct_timer
  import gct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer pins
  input wire logic timer_input_pin,
  output logic timer_output_pin,
  output logic timer_output_oe,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [GCT_CTRL_WIDTH-1:0] ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [15:0] capture_reg;
  logic [3:0] status_reg;
  logic [3:0] status_next;
  logic [3:0] mask_reg;
  logic [3:0] events;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic addr_phase;
  logic [31:0] rd_value;
  logic input_sync;
  logic input_prev_reg;
  logic timer_en;
  logic input_polarity_bit;
  logic [GCT_PRESCALE_SELECT_WIDTH-1:0] prescale_select;
  logic [2:0] timer_mode_field;
  logic timer_mode_high_bit;
  logic alt_en;
  logic [3:0] mode;
  logic is_compare;
  logic is_gated;
  logic is_caprst;
  logic input_active;
  logic prescale_select_advance;
  logic tick;
  logic at_reload;
  logic reload_hit;
  logic deassert_hit;
  logic capture_edge;
  logic count_wr;
  logic ctrl_wr;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign timer_en = ctrl_reg[GCT_CTRL_EN_BIT];
  assign input_polarity_bit = ctrl_reg[GCT_CTRL_POL_BIT];
  assign prescale_select = ctrl_reg[GCT_CTRL_PRESCALE_SELECT_LSB +: GCT_PRESCALE_SELECT_WIDTH];
  assign timer_mode_field = ctrl_reg[GCT_CTRL_MODE_LSB +: 3];
  assign timer_mode_high_bit = ctrl_reg[GCT_CTRL_MODEHI_BIT];
  assign alt_en = ctrl_reg[GCT_CTRL_ALT_BIT];
  // [R13] mode code
  assign mode = {timer_mode_high_bit, timer_mode_field};
  assign is_compare = (mode == GCT_MODE_COMPARE);
  assign is_gated = (mode == GCT_MODE_GATED);
  assign is_caprst = (mode == GCT_MODE_CAPRST);

  // ----------------------------------------------------------------
  // Timer input
  // ----------------------------------------------------------------
  gct_sync u_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(timer_input_pin),
    .sync_out(input_sync)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      input_prev_reg <= 1'b0;
    else
      input_prev_reg <= input_sync;
  end

  // Polarity 1 means active low
  assign input_active = input_sync ^ input_polarity_bit;

  // [R11] edge choice by polarity
  assign capture_edge = timer_en && is_caprst &&
    (input_polarity_bit ? (input_prev_reg && !input_sync)
                        : (!input_prev_reg && input_sync));

  // [R6] deassertion event
  assign deassert_hit = timer_en && is_gated &&
    ((input_prev_reg ^ input_polarity_bit) && !input_active);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // [R1] [R5] [R8] system clock only; gate holds prescaler too
  assign prescale_select_advance = timer_en && (is_compare || is_caprst || (is_gated && input_active));

  // [R12] cleared while disabled
  gct_prescaler u_prescale_select
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(!timer_en),
    .advance(prescale_select_advance),
    .prescale_select(prescale_select),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign at_reload = (count_reg == reload_reg);
  assign reload_hit = tick && at_reload;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count_reg <= GCT_COUNT_RESET;
    else if (count_wr)
      count_reg <= hwdata[15:0];
    else if (capture_edge)
      count_reg <= GCT_COUNT_RESTART;
    else if (tick)
    begin
      // [R15] compare keeps counting past match
      if (is_compare || !at_reload)
        count_reg <= count_reg + 16'h0001;
      // [R7] restart at 0001
      else
        count_reg <= GCT_COUNT_RESTART;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      capture_reg <= GCT_COUNT_RESET;
    else if (capture_edge)
      capture_reg <= count_reg;
  end

  // ----------------------------------------------------------------
  // Timer output
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_output_pin <= 1'b0;
    // [R14] idle level is polarity
    else if (!timer_en)
      timer_output_pin <= input_polarity_bit;
    // [R9] toggle on reload
    else if (reload_hit)
      timer_output_pin <= !timer_output_pin;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_output_oe <= 1'b0;
    else
      timer_output_oe <= alt_en;
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  always_comb
  begin
    events = '0;
    // [R6] [R15] reload or compare match
    events[GCT_EV_RELOAD] = reload_hit;
    events[GCT_EV_DEASSERT] = deassert_hit;
    events[GCT_EV_CAPTURE] = capture_edge;
    events[GCT_EV_COUNT] = tick;
  end

  // New events win over a same-cycle clear
  always_comb
  begin
    status_next = status_reg;
    if (wr_pend_reg && wr_addr_reg == GCT_STATUS_OFS)
      status_next = status_next & ~hwdata[3:0];
    status_next = status_next | events;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states; hsize ignored, whole words only
  assign addr_phase = hsel && hready && (htrans == GCT_HTRANS_NONSEQ || htrans[1]);
  assign ctrl_wr = wr_pend_reg && (wr_addr_reg == GCT_CTRL_OFS);
  assign count_wr = wr_pend_reg && (wr_addr_reg == GCT_COUNT_OFS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= GCT_CTRL_RESET;
    else if (ctrl_wr)
      ctrl_reg <= hwdata[GCT_CTRL_WIDTH-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reload_reg <= GCT_RELOAD_RESET;
    else if (wr_pend_reg && wr_addr_reg == GCT_RELOAD_OFS)
      reload_reg <= hwdata[15:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_reg <= '0;
    else if (wr_pend_reg && wr_addr_reg == GCT_MASK_OFS)
      mask_reg <= hwdata[3:0];
  end

  always_comb
  begin
    rd_value = 32'h00000000;
    if (haddr[31:8] == 24'h000000)
    begin
      case (haddr[7:0])
        GCT_CTRL_OFS: rd_value = {22'h000000, ctrl_reg};
        GCT_COUNT_OFS: rd_value = {16'h0000, count_reg};
        GCT_RELOAD_OFS: rd_value = {16'h0000, reload_reg};
        GCT_STATUS_OFS: rd_value = {28'h0000000, status_reg};
        GCT_MASK_OFS: rd_value = {28'h0000000, mask_reg};
        GCT_PINS_OFS: rd_value = {30'h00000000, timer_output_pin, input_sync};
        GCT_CAPTURE_OFS: rd_value = {16'h0000, capture_reg};
        default: rd_value = 32'h00000000;
      endcase
    end
  end

  // Read data sampled in the address phase, held for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_phase && !hwrite)
      hrdata <= rd_value;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= GCT_HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= GCT_HRESP_OKAY;
    end
  end

endmodule : gct_timer

`default_nettype wire

// ---- dv/gct_pin_model.sv ----
// Source model driving the timer input pin
`timescale 1ns/1ps
`default_nettype none

module gct_pin_model
(
  // Clock
  input wire logic hclk,
  // Requested level, or toggle every cycle
  input wire logic level,
  input wire logic wiggle,
  // Pin
  output logic pin
);
  initial pin = 1'b0;
  // Changes only after an edge, like a real driver
  always @(posedge hclk)
    pin <= wiggle ? ~pin : level;
endmodule : gct_pin_model

`default_nettype wire

// ---- dv/gct_timer_monitor.sv ----
// Port checker for the gated compare timer
`timescale 1ns/1ps
`default_nettype none

module gct_timer_monitor
  import gct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic timer_output_pin,
  input wire logic timer_output_oe,
  input wire logic irq
);
  logic ap;
  logic wc;
  logic wr_q;
  logic [7:0] a_q;
  logic [31:0] wd_q;
  assign ap = hsel && hready && htrans[1];
  assign wc = wr_q && a_q == GCT_CTRL_OFS;
  // Data phase tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
      wd_q <= 32'h0;
    end
    else
    begin
      wr_q <= ap && hwrite;
      if (ap)
        a_q <= haddr[7:0];
      if (wr_q)
        wd_q <= hwdata;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout)
    else $error("ready low");
  a_resp_okay: assert property (hresp == GCT_HRESP_OKAY)
    else $error("bad response");
  a_unmapped_zero: assert property (ap && !hwrite && haddr >= 32'h1c |-> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_upper: assert property (ap && !hwrite && haddr == 32'h0 |-> ##1 hrdata[31:10] == 22'h0)
    else $error("control upper bits set");
  a_oe_follows: assert property (wc |-> ##2 timer_output_oe == wd_q[9])
    else $error("output enable wrong");
  a_oe_only_write: assert property (!$stable(timer_output_oe) |-> $past(wc) || $past(wc, 2))
    else $error("output enable moved alone");
  a_idle_polarity: assert property (wc && !hwdata[0] |-> ##2 timer_output_pin == wd_q[1])
    else $error("idle output wrong");
  a_mask_quiet: assert property (wr_q && a_q == GCT_MASK_OFS && hwdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("masked irq high");
endmodule : gct_timer_monitor

bind gct_timer gct_timer_monitor mon_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_output_pin, .timer_output_oe, .irq);

`default_nettype wire

// ---- dv/test_gated_compare_timer.sv ----
// Self-checking bench for the gated compare timer
`timescale 1ns/1ps
`default_nettype none

module test_gated_compare_timer
  import gct_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic lvl = 1'b0;
  logic wig = 1'b0;
  logic o;
  logic [31:0] rd;
  logic [31:0] c;
  wire hready, hreadyout, hresp, pin, tout, toe, irq;
  wire [31:0] hrdata;
  int errors = 0;
  int checked = 0;
  assign hready = hreadyout;
  initial forever #2.5 hclk = ~hclk;
  gct_timer dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .timer_input_pin(pin), .timer_output_pin(tout),
    .timer_output_oe(toe), .irq);
  gct_pin_model pin_u (.hclk, .level(lvl), .wiggle(wig), .pin);

  task automatic results;
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick

  task automatic wt;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        errors++;
        results();
      end
      @(posedge hclk);
    end
  endtask : wt

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= GCT_HTRANS_NONSEQ;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask : bus

  function automatic logic [31:0] cw(logic en, logic pol, logic [2:0] pr, logic [3:0] m, logic alt);
    return {22'h0, alt, m, pr, pol, en};
  endfunction : cw

  task automatic t_regs;
    bus(0, GCT_CTRL_OFS, 0);
    chk(rd, 32'h0);
    bus(1, 8'h1c, 32'h1);
    bus(0, 8'h1c, 0);
    chk(rd, 32'h0);
    bus(1, GCT_RELOAD_OFS, 32'hffff1234);
    bus(0, GCT_RELOAD_OFS, 0);
    chk(rd, 32'h1234);
  endtask : t_regs

  task automatic t_idle;
    for (int p = 0; p < 2; p++)
    begin
      bus(1, GCT_CTRL_OFS, cw(0, p[0], 0, 0, p[0]));
      tick(2);
      chk({31'h0, tout}, p);
      chk({31'h0, toe}, p);
    end
  endtask : t_idle

  task automatic t_gated;
    int n;
    bus(1, GCT_CTRL_OFS, cw(0, 0, 0, GCT_MODE_GATED, 1));
    bus(1, GCT_COUNT_OFS, 1);
    bus(1, GCT_RELOAD_OFS, 3);
    bus(1, GCT_MASK_OFS, 32'h3);
    bus(1, GCT_STATUS_OFS, 32'hf);
    bus(1, GCT_CTRL_OFS, cw(1, 0, 0, GCT_MODE_GATED, 1));
    tick(8);
    bus(0, GCT_COUNT_OFS, 0);
    chk(rd, 32'h1);
    lvl <= 1'b1;
    tick(12);
    chk({31'h0, irq}, 1);
    o = tout;
    n = 0;
    while (tout === o && n < 6)
    begin
      tick(1);
      n++;
    end
    chk({31'h0, tout !== o}, 1);
    bus(0, GCT_COUNT_OFS, 0);
    chk({31'h0, rd >= 1 && rd <= 3}, 1);
    lvl <= 1'b0;
    tick(6);
    bus(1, GCT_STATUS_OFS, 32'h1);
    bus(0, GCT_STATUS_OFS, 0);
    chk(rd[1:0], 2'b10);
    bus(0, GCT_COUNT_OFS, 0);
    c = rd;
    tick(4);
    bus(0, GCT_COUNT_OFS, 0);
    chk(rd, c);
    bus(0, GCT_PINS_OFS, 0);
    chk(rd[0], 1'b0);
  endtask : t_gated

  task automatic t_compare;
    int n;
    bus(1, GCT_CTRL_OFS, cw(0, 0, 2, GCT_MODE_COMPARE, 1));
    bus(1, GCT_COUNT_OFS, 0);
    bus(1, GCT_RELOAD_OFS, 5);
    bus(1, GCT_MASK_OFS, 32'h1);
    bus(1, GCT_STATUS_OFS, 32'hf);
    wig <= 1'b1;
    o = tout;
    bus(1, GCT_CTRL_OFS, cw(1, 0, 2, GCT_MODE_COMPARE, 1));
    n = 0;
    while (irq !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk({31'h0, n >= 20 && n <= 28}, 1);
    chk({31'h0, tout !== o}, 1);
    bus(0, GCT_COUNT_OFS, 0);
    chk({31'h0, rd >= 5 && rd <= 8}, 1);
    wig <= 1'b0;
  endtask : t_compare

  task automatic t_capture;
    for (int p = 0; p < 2; p++)
    begin
      bus(1, GCT_CTRL_OFS, cw(0, p[0], 0, GCT_MODE_CAPRST, 0));
      lvl <= ~p[0];
      bus(1, GCT_MASK_OFS, 32'h4);
      bus(1, GCT_CTRL_OFS, cw(1, p[0], 0, GCT_MODE_CAPRST, 0));
      tick(4);
      bus(1, GCT_STATUS_OFS, 32'hf);
      lvl <= p[0];
      tick(6);
      chk({31'h0, irq}, 0);
      lvl <= ~p[0];
      tick(6);
      chk({31'h0, irq}, 1);
      bus(1, GCT_MASK_OFS, 0);
      bus(1, GCT_STATUS_OFS, 32'hf);
      bus(0, GCT_STATUS_OFS, 0);
      chk(rd[2], 1'b0);
    end
  endtask : t_capture

  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_idle();
    t_gated();
    t_compare();
    t_capture();
    results();
  end
endmodule : test_gated_compare_timer

`default_nettype wire
